// ==== sbsp_consts.vh ====
// Purpose: Constants for the serial bus and two-wire shift port.
// Assumes: 50 MHz core clock; serial clock sampled through two flip-flops.
// Notes: Divider count sets the master serial clock half period.
`ifndef SBSP_CONSTS_VH
`define SBSP_CONSTS_VH
`define SBSP_BITS        4'h8
`define SBSP_CNT_ZERO    4'h0
`define SBSP_ONES        8'hff
`define SBSP_ZERO8       8'h00
`define SBSP_MSB         7
`define SBSP_HALF_NS     80
`define SBSP_CLK_NS      20
`define SBSP_HALF_CYC    ((`SBSP_HALF_NS + `SBSP_CLK_NS - 1) / `SBSP_CLK_NS)
`define SBSP_DIV_W       3
`endif

// ==== sbsp_sync.v ====
// Purpose: Two flip-flop synchroniser with edge detection on the second stage.
// Assumes: Input is asynchronous to core_clk_i.
// Notes: Only the second stage feeds the edge logic.
`timescale 1ns/10ps
`include "sbsp_consts.vh"
module sbsp_sync (
    input  wire core_clk_i,
    input  wire nrst_i,
    input  wire async_i,
    input  wire init_i,
    output reg  level_o,
    output wire rise_o,
    output wire fall_o
);
    reg meta;
    reg last;
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta    <= 1'b1;
            level_o <= 1'b1;
            last    <= 1'b1;
        end else begin
            meta    <= async_i;
            level_o <= meta;
            last    <= level_o;
        end
    end
    assign rise_o = level_o & ~last & ~init_i;
    assign fall_o = ~level_o & last & ~init_i;
endmodule // sbsp_sync

// ==== sbsp_clkgen.v ====
// Purpose: Master serial clock divider for the shift port.
// Assumes: run_i is high while a master transfer is in progress.
// Notes: When stopped, the clock holds its present level.
`timescale 1ns/10ps
`include "sbsp_consts.vh"
module sbsp_clkgen (
    input  wire core_clk_i,
    input  wire nrst_i,
    input  wire run_i,
    output reg  sclk_o
);
    reg [`SBSP_DIV_W-1:0] div;
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div    <= {`SBSP_DIV_W{1'b0}};
            sclk_o <= 1'b1;
        end else if (!run_i) begin
            div <= {`SBSP_DIV_W{1'b0}};
        end else if (div == `SBSP_HALF_CYC - 1) begin
            div    <= {`SBSP_DIV_W{1'b0}};
            sclk_o <= ~sclk_o;
        end else begin
            div <= div + 1'b1;
        end
    end
endmodule // sbsp_clkgen

// ==== sbsp_port.v ====
// Purpose: Shift port with serial bus mode and two-wire clocked mode.
// Assumes: Serial clock and data pins are asynchronous and pass two flip-flops.
// Notes: Control bits are plain ports; write strobes are one-cycle pulses.
// What this block does
// - Byte copied to address register; match flag after transfer reports transmit success.
// - Serial bus mode shifts on each serial clock falling edge.
// - Serial bus mode sends bytes most significant bit first.
// - Serial bus mode captures data pin on serial clock rising edge.
// - Bus mode write starts only if enabled and clock idle or high.
// - Enabling after a write does not start a transfer.
// - Software preloads ones for receive; wake-up flag forces the driver off.
// - Write during slave busy is kept and starts once line is ready.
// - After eight bits the port stops and raises its interrupt request, except on a wake-up address mismatch.
// - First address after bus release selects; wake-up interrupts only on match.
// - Wake-up does not clear busy; busy lasts until next falling edge.
// - Software toggles port latches around bus release trigger before first byte.
// - Master checks ready by reading data pin as input after acknowledge.
// - Two-wire mode when both mode bits set and wait bit clear.
// - Two-wire transmit sends most significant bit first on falling clock edges.
// - Two-wire receive enters at least significant end on rising clock edges.
// - Master starts on write; slave releases clock pin and waits.
// - Two-wire interrupt request rises on the eighth rising clock edge.
// - Two-wire master stops clock at eighth rising edge and holds level.
// - Command and release triggers are ignored in two-wire mode.
// - Two-wire write starts only if enabled and clock idle or low.
// - Two-wire sender shifts back actual bus level for error checking.
// - Receiver pulls data low for one clock period as acknowledge.
// - Wake-up address mismatch clears bus release detected flag, no interrupt.
// - Slave holds data line high as ready before and after transfers.
`timescale 1ns/10ps
`include "sbsp_consts.vh"
module sbsp_port (
    input  wire       core_clk_i,
    input  wire       nrst_i,
    input  wire       port_enable_flag_i,
    input  wire       master_i,
    input  wire       mode_select_bit1_i,
    input  wire       mode_select_bit2_i,
    input  wire       wait_select_bit1_i,
    input  wire       wake_up_flag_i,
    input  wire       ack_enable_i,
    input  wire       ack_trigger_i,
    input  wire       busy_enable_i,
    input  wire       bus_release_trigger_i,
    input  wire       command_trigger_i,
    input  wire       select_pin_b_i,
    input  wire       sr_write_i,
    input  wire [7:0] sr_wdata_i,
    input  wire       sva_write_i,
    input  wire [7:0] sva_wdata_i,
    input  wire       irq_clear_i,
    input  wire       sclk_i,
    input  wire       data_a_i,
    input  wire       data_b_i,
    output reg  [7:0] shift_register_o,
    output reg  [7:0] slave_address_register_o,
    output reg        address_match_flag_o,
    output reg        port_interrupt_request_o,
    output reg        bus_release_detected_o,
    output reg        busy_o,
    output reg        sclk_o,
    output reg        sclk_oe_o,
    output reg        data_a_o,
    output reg        data_a_oe_o,
    output reg        data_b_o,
    output reg        data_b_oe_o
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_WAIT = 4'b0010;
    localparam ST_RUN  = 4'b0100;
    localparam ST_ACK  = 4'b1000;

    reg  [3:0] state;
    reg  [3:0] bit_cnt;
    reg  [7:0] sr;
    reg        out_bit;
    reg        ack_drive;
    reg        busy;
    reg        sel_addr;
    reg        start_req;
    wire       two_wire;
    wire       data_in_raw;
    wire       sck_lvl;
    wire       sck_rise;
    wire       sck_fall;
    wire       din_lvl;
    wire       gen_sclk;
    wire       line_idle;
    wire       start_ok;
    wire       drive_low;
    reg        gen_last;
    wire       ev_rise;
    wire       ev_fall;
    wire       bit_now;

    // Both mode bits set with wait bit clear selects two-wire; other codes are bus mode here.
    assign two_wire    = mode_select_bit1_i & mode_select_bit2_i & ~wait_select_bit1_i;
    assign data_in_raw = select_pin_b_i ? data_b_i : data_a_i;

    sbsp_sync u_sck_sync (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .async_i    (sclk_i),
        .init_i     (1'b0),
        .level_o    (sck_lvl),
        .rise_o     (sck_rise),
        .fall_o     (sck_fall)
    );

    sbsp_sync u_din_sync (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .async_i    (data_in_raw),
        .init_i     (1'b0),
        .level_o    (din_lvl),
        .rise_o     (),
        .fall_o     ()
    );

    sbsp_clkgen u_clkgen (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .run_i      (master_i & (state == ST_RUN)),
        .sclk_o     (gen_sclk)
    );

    // The master takes its edges straight from the divider; waiting on the pin
    // synchroniser would let the divider run on past the eighth rising edge.
    assign ev_rise   = master_i ? (gen_sclk & ~gen_last) : sck_rise;
    assign ev_fall   = master_i ? (~gen_sclk & gen_last) : sck_fall;
    // The next bit drives the pin in the fall cycle itself, so a slave settles within half a period.
    assign bit_now   = (state == ST_RUN && ev_fall && bit_cnt != `SBSP_CNT_ZERO) ? sr[`SBSP_MSB] : out_bit;
    assign line_idle = (state == ST_IDLE) &&
                       (two_wire ? ~sck_lvl | master_i : sck_lvl | master_i);
    assign start_ok  = port_enable_flag_i & line_idle;
    // Wake-up keeps the driver off while receiving addresses.
    assign drive_low = ack_drive | busy | (~bit_now & ~(wake_up_flag_i & ~two_wire));

    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state                    <= ST_IDLE;
            bit_cnt                  <= `SBSP_CNT_ZERO;
            sr                       <= `SBSP_ONES;
            out_bit                  <= 1'b1;
            ack_drive                <= 1'b0;
            busy                     <= 1'b0;
            sel_addr                 <= 1'b0;
            start_req                <= 1'b0;
            gen_last                 <= 1'b1;
            shift_register_o         <= `SBSP_ONES;
            slave_address_register_o <= `SBSP_ZERO8;
            address_match_flag_o     <= 1'b0;
            port_interrupt_request_o <= 1'b0;
            bus_release_detected_o   <= 1'b0;
            busy_o                   <= 1'b0;
            sclk_o                   <= 1'b1;
            sclk_oe_o                <= 1'b0;
            data_a_o                 <= 1'b0;
            data_a_oe_o              <= 1'b0;
            data_b_o                 <= 1'b0;
            data_b_oe_o              <= 1'b0;
        end else begin
            gen_last <= gen_sclk;
            if (sva_write_i) begin
                slave_address_register_o <= sva_wdata_i;
            end
            if (bus_release_trigger_i && !two_wire) begin
                bus_release_detected_o <= 1'b1;
                sel_addr               <= 1'b1;
            end
            if (command_trigger_i && !two_wire) begin
                sel_addr <= 1'b0;
            end
            // A write only latches data; enable is sampled at the write itself.
            if (sr_write_i) begin
                sr        <= sr_wdata_i;
                out_bit   <= sr_wdata_i[`SBSP_MSB];
                start_req <= port_enable_flag_i;
            end
            // Clearing busy releases the line only at the next falling serial clock.
            if (!busy_enable_i && busy && ev_fall) begin
                busy <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (start_req && start_ok && !sr_write_i) begin
                        start_req <= 1'b0;
                        bit_cnt   <= `SBSP_CNT_ZERO;
                        state     <= (busy && !two_wire) ? ST_WAIT : ST_RUN;
                    end
                end
                ST_WAIT: begin
                    if (!busy && din_lvl) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (ev_fall && bit_cnt != `SBSP_CNT_ZERO) begin
                        out_bit <= sr[`SBSP_MSB];
                    end
                    if (ev_rise) begin
                        sr      <= {sr[6:0], din_lvl};
                        bit_cnt <= bit_cnt + 1'b1;
                        if (bit_cnt == `SBSP_BITS - 1) begin
                            state            <= ST_ACK;
                            shift_register_o <= {sr[6:0], din_lvl};
                            address_match_flag_o <= ({sr[6:0], din_lvl} == slave_address_register_o);
                            if (two_wire) begin
                                port_interrupt_request_o <= 1'b1;
                            end else if (wake_up_flag_i && sel_addr) begin
                                sel_addr <= 1'b0;
                                if ({sr[6:0], din_lvl} == slave_address_register_o) begin
                                    port_interrupt_request_o <= 1'b1;
                                end else begin
                                    bus_release_detected_o <= 1'b0;
                                end
                            end else begin
                                port_interrupt_request_o <= 1'b1;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    out_bit <= 1'b1;
                    if (!two_wire && ack_enable_i && !ack_drive && ev_fall) begin
                        ack_drive <= 1'b1;
                    end else if (ack_drive && ev_fall) begin
                        ack_drive <= 1'b0;
                        busy      <= busy_enable_i;
                        state     <= ST_IDLE;
                    end else if (!ack_enable_i || two_wire) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            if (ack_trigger_i && !two_wire && state == ST_IDLE) begin
                ack_drive <= 1'b1;
            end
            // Set wins over a clear arriving in the same cycle.
            if (irq_clear_i && !(state == ST_RUN && ev_rise && bit_cnt == `SBSP_BITS - 1)) begin
                port_interrupt_request_o <= 1'b0;
            end
            busy_o      <= busy;
            sclk_o      <= gen_sclk;
            sclk_oe_o   <= master_i;
            data_a_o    <= 1'b0;
            data_b_o    <= 1'b0;
            data_a_oe_o <= drive_low & ~select_pin_b_i;
            data_b_oe_o <= drive_low & select_pin_b_i;
        end
    end
endmodule // sbsp_port

// ==== sbsp_port_asserts.sv ====
// Purpose: Port-level checks for the shift port.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Helper logic records whether an enabled write armed a transfer.
`timescale 1ns/10ps
module sbsp_port_asserts (
    input wire       core_clk_i,
    input wire       nrst_i,
    input wire       port_enable_flag_i,
    input wire       master_i,
    input wire       sr_write_i,
    input wire       irq_clear_i,
    input wire       select_pin_b_i,
    input wire       port_interrupt_request_o,
    input wire       sclk_o,
    input wire       sclk_oe_o,
    input wire       data_a_oe_o
);
    reg       live;
    reg       armed;
    reg [3:0] nfall;
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            live <= 1'b0;
            armed <= 1'b0;
            nfall <= 4'h0;
        end else begin
            live <= 1'b1;
            armed <= (sr_write_i && port_enable_flag_i) || (armed && !$rose(port_interrupt_request_o));
            nfall <= (sr_write_i && port_enable_flag_i) ? 4'h0 : nfall + {3'h0, $fell(sclk_o)};
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    // The master clock idles high, so a half period low must end high again.
    sequence s_low_half; !sclk_o [*4] ##1 sclk_o; endsequence
    sequence s_held; sclk_o [*8]; endsequence
    AST_SCLK_DIR: assert property (live && $stable(master_i) |-> sclk_oe_o == master_i) else $error("clock drive wrong");
    AST_IRQ_HOLD: assert property (port_interrupt_request_o && !irq_clear_i |=> port_interrupt_request_o) else $error("irq lost");
    AST_CLK_NEEDS_WRITE: assert property ($fell(sclk_o) |-> armed) else $error("clock ran unarmed");
    AST_IRQ_NEEDS_WRITE: assert property ($rose(port_interrupt_request_o) |-> armed) else $error("irq unarmed");
    AST_HALF_PERIOD: assert property ($fell(sclk_o) |-> s_low_half) else $error("half period wrong");
    AST_EIGHT_CLOCKS: assert property ($rose(port_interrupt_request_o) && master_i |-> nfall == 4'h8) else $error("not 8 clocks");
    AST_CLK_STOPS: assert property ($rose(port_interrupt_request_o) && master_i |-> s_held) else $error("clock not held");
    AST_PIN_A_QUIET: assert property (live && select_pin_b_i && $stable(select_pin_b_i) |-> !data_a_oe_o) else $error("pin a driven");
endmodule // sbsp_port_asserts
bind sbsp_port sbsp_port_asserts i_chk (.core_clk_i, .nrst_i, .port_enable_flag_i, .master_i, .sr_write_i, .irq_clear_i,
    .select_pin_b_i, .port_interrupt_request_o, .sclk_o, .sclk_oe_o, .data_a_oe_o);

// ==== sbsp_partner.sv ====
// Purpose: Far-side device on the wire-AND clock and data lines.
// Assumes: Both lines are pulled up, so a released line reads high.
// Notes: Sends its byte MSB first and clocks eight 160 ns periods (a 1280 ns frame) on request.
`timescale 1ns/10ps
module sbsp_partner (
    input  wire       scl_i,
    input  wire       sda_i,
    input  wire       load_i,
    input  wire       gen_i,
    input  wire [7:0] tx_i,
    output reg        sda_oe_o = 1'b0,
    output reg        scl_oe_o = 1'b0,
    output reg        scl_o    = 1'b1,
    output reg  [7:0] rx_o     = 8'h00
);
    reg [7:0] sh = 8'hff;
    integer   n  = 8;
    always @(posedge load_i) begin
        sh = tx_i;
        n = 0;
        sda_oe_o = ~tx_i[7];
    end
    always @(posedge scl_i) if (n < 8) begin
        rx_o = {rx_o[6:0], sda_i};
        n = n + 1;
        // Releasing only after the hold time keeps the last bit valid for the sampler.
        if (n == 8) sda_oe_o <= #100 1'b0;
    end
    always @(negedge scl_i) if (n > 0 && n < 8) begin
        sh = {sh[6:0], 1'b1};
        sda_oe_o = ~sh[7];
    end
    always @(posedge gen_i) begin
        scl_oe_o = 1'b1;
        repeat (8) begin
            scl_o = 1'b0;
            #80;
            scl_o = 1'b1;
            #80;
        end
        scl_oe_o = 1'b0;
    end
endmodule // sbsp_partner

// ==== sbsp_port_tb.sv ====
// Purpose: Self-checking bench for the shift port.
// Assumes: Partner on pulled-up wire-AND lines with a 160 ns link clock.
// Notes: Random bytes and modes from an LFSR, corner cases first.
`timescale 1ns/10ps
module sbsp_port_tb;
    reg        core_clk_i = 1'b0;
    reg        nrst_i     = 1'b0;
    reg        en, mst, md1, md2, wt, selb, cmdt, relt, srw, clr, pload, pgen;
    reg  [7:0] wd, pd;
    reg [31:0] lf         = 32'hbf60;
    wire [7:0] sro, pro, sva;
    wire       reld, bsy;
    wire       irq, match, scko, sckoe, aoe, boe, poe, psoe, psck;
    integer    n_mismatch = 0;
    integer    n_checks   = 0;
    integer    cyc        = 0;
    integer    k;
    wire       scl   = sckoe ? scko : (psoe ? psck : 1'b1);
    wire       sda_a = !aoe && !(poe && !selb);
    wire       sda_b = !boe && !(poe && selb);
    sbsp_port i_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .port_enable_flag_i(en), .master_i(mst),
        .mode_select_bit1_i(md1), .mode_select_bit2_i(md2), .wait_select_bit1_i(wt), .wake_up_flag_i(1'b0),
        .ack_enable_i(1'b0), .ack_trigger_i(1'b0), .busy_enable_i(1'b0), .bus_release_trigger_i(relt),
        .command_trigger_i(cmdt), .select_pin_b_i(selb), .sr_write_i(srw), .sr_wdata_i(wd), .sva_write_i(srw),
        .sva_wdata_i(wd), .irq_clear_i(clr), .sclk_i(scl), .data_a_i(sda_a), .data_b_i(sda_b),
        .shift_register_o(sro), .slave_address_register_o(sva), .address_match_flag_o(match),
        .port_interrupt_request_o(irq), .bus_release_detected_o(reld), .busy_o(bsy), .sclk_o(scko), .sclk_oe_o(sckoe),
        .data_a_o(), .data_a_oe_o(aoe), .data_b_o(), .data_b_oe_o(boe));
    sbsp_partner i_far (.scl_i(scl), .sda_i(selb ? sda_b : sda_a), .load_i(pload), .gen_i(pgen), .tx_i(pd),
        .sda_oe_o(poe), .scl_oe_o(psoe), .scl_o(psck), .rx_o(pro));
    initial forever #10 core_clk_i = ~core_clk_i;
    function [31:0] nxt(input [31:0] v);
        nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task close_out;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_mismatch);
            if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // The wire-AND bus returns the AND of both senders to each shifter.
    task xfer(input two, input m, input [7:0] d, input [7:0] p);
        integer w;
        begin
            @(negedge core_clk_i);
            {md1, md2, wt} = two ? 3'b110 : ((lf[2:0] == 3'b110) ? 3'b111 : lf[2:0]);
            {mst, selb, en, clr, srw, wd} = {m, lf[3], 3'b111, d};
            @(negedge core_clk_i);
            {clr, srw} = 2'b00;
            repeat (3) @(negedge core_clk_i);
            {pd, pload, cmdt, relt} = {p, 1'b1, two, two};
            @(negedge core_clk_i);
            {pload, cmdt, relt, pgen} = {3'b000, !m};
            @(negedge core_clk_i);
            pgen = 1'b0;
            w = 0;
            while (irq !== 1'b1 && w < 400) begin
                @(negedge core_clk_i);
                w = w + 1;
            end
            repeat (12) @(negedge core_clk_i);
            chk({7'h0, irq}, 8'h01);
            chk(sro, d & p);
            chk(pro, d & p);
            chk({7'h0, match}, {7'h0, (d & p) == d});
            chk(sva, d);
            chk({6'h0, reld, bsy}, {6'h0, !two && reld, 1'b0});
            chk({6'h0, sckoe, scko}, {6'h0, m, 1'b1});
        end
    endtask
    always @(posedge core_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            close_out;
        end
    end
    initial begin
        {en, mst, md1, md2, wt, selb, cmdt, relt, srw, clr, pload, pgen, wd, pd} = 28'h0;
        repeat (4) @(negedge core_clk_i);
        nrst_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        {md1, md2, mst, srw, clr, wd} = {4'hf, 1'b1, 8'h5a};
        @(negedge core_clk_i);
        {srw, clr, en} = 3'b001;
        repeat (60) @(negedge core_clk_i);
        chk({7'h0, irq}, 8'h00);
        chk({7'h0, scko}, 8'h01);
        xfer(1'b1, 1'b1, 8'h00, 8'hff);
        xfer(1'b1, 1'b0, 8'hff, 8'ha5);
        xfer(1'b0, 1'b1, 8'h81, 8'hff);
        xfer(1'b0, 1'b0, 8'hff, 8'h3c);
        xfer(1'b1, 1'b1, 8'hf0, 8'h5f);
        for (k = 0; k < 12; k = k + 1) begin
            lf = nxt(lf);
            xfer(lf[4], lf[5], lf[5] ? lf[15:8] : 8'hff, lf[6] ? 8'hff : lf[23:16]);
        end
        close_out;
    end
endmodule // sbsp_port_tb
